// file: common/dbed_if.sv
/*
  Parallel link between the host end and the device end.
  Assumes one shared clock; the testbench instantiates and joins both ends.
*/
`timescale 1ns/1ps
interface dbed_if;
  import dbed_pkg::*;
  // buffer access
  logic hb_sel;
  logic [IDX_W-1:0] hb_addr;
  logic hb_wr;
  logic hb_rd;
  logic [15:0] hb_wdata;
  logic [15:0] hb_rdata;
  logic hb_rvalid;
  // address registers, written together
  logic ad_wr;
  logic [BLK_W-1:0] ad_blk;
  logic [PAGE_W-1:0] ad_page;
  logic [SECT_W-1:0] ad_sect;
  // command and configuration
  logic cmd_valid;
  dbed_op_t cmd_op;
  logic cmd_buf;
  logic [15:0] cfg1;
  // status
  logic busy;
  logic done;
  logic fail;
  dbed_ecc_t ecc_main;
  dbed_ecc_t ecc_spare;
  logic ecc_valid;
  modport dev (
    input hb_sel, hb_addr, hb_wr, hb_rd, hb_wdata, ad_wr, ad_blk, ad_page, ad_sect,
    input cmd_valid, cmd_op, cmd_buf, cfg1,
    output hb_rdata, hb_rvalid, busy, done, fail, ecc_main, ecc_spare, ecc_valid
  );
  modport host (
    output hb_sel, hb_addr, hb_wr, hb_rd, hb_wdata, ad_wr, ad_blk, ad_page, ad_sect,
    output cmd_valid, cmd_op, cmd_buf, cfg1,
    input hb_rdata, hb_rvalid, busy, done, fail, ecc_main, ecc_spare, ecc_valid
  );
endinterface

// file: common/dbed_pkg.sv
/*
  Shared constants and types for the dual-buffer ECC data path: geometry,
  spare-area layout, ECC code layout, command and status encodings.
  Assumes both ends are compiled against this package and share one clock.
*/
package dbed_pkg;
  // ==========================================================
  // geometry
  localparam int MAIN_WORDS = 256;
  localparam int SPARE_WORDS = 8;
  localparam int SECT_WORDS = MAIN_WORDS + SPARE_WORDS;
  localparam int IDX_W = 9;
  localparam int BLK_W = 10;
  localparam int PAGE_W = 6;
  localparam int SECT_W = 2;
  localparam int ARR_AW = BLK_W + PAGE_W + SECT_W + IDX_W;
  // ==========================================================
  // spare layout, as word indices within a sector
  localparam logic [IDX_W-1:0] W_MARK = 9'h101;
  localparam logic [IDX_W-1:0] W_SPECC0 = 9'h102;
  localparam logic [IDX_W-1:0] W_SPECC1 = 9'h103;
  localparam logic [IDX_W-1:0] W_CODE0 = 9'h104;
  localparam logic [IDX_W-1:0] W_CODE1 = 9'h105;
  localparam logic [IDX_W-1:0] W_CODE2 = 9'h106;
  localparam logic [IDX_W-1:0] W_LAST = 9'h107;
  localparam logic [15:0] MARK_GOOD = 16'hFFFF;
  // ==========================================================
  // ECC code layout: {odd parities, even parities}
  localparam int MAIN_PAIRS = 12;
  localparam int SPARE_PAIRS = 5;
  localparam int MAIN_CODE_W = 24;
  localparam int SPARE_CODE_W = 10;
  localparam int BYPASS_BIT = 9;
  localparam logic [15:0] CFG1_RST = 16'h0000;
  typedef enum logic [1:0] {
    DBED_OP_LOAD,
    DBED_OP_PROG,
    DBED_OP_BOOT
  } dbed_op_t;
  typedef enum logic [1:0] {
    DBED_ECC_NONE,
    DBED_ECC_ONE,
    DBED_ECC_TWO
  } dbed_ecc_t;
endpackage

// file: hdl/dbed_device.sv
/*
  Device end: two host buffers, the load/program engine toward the array
  and the ECC generator/checker.
  Assumes an array port that returns read data the cycle after o_arr_re.
*/
`timescale 1ns/1ps
module dbed_device
  import dbed_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  dbed_if.dev bus,
  output logic o_arr_re,
  output logic o_arr_we,
  output logic [ARR_AW-1:0] o_arr_addr,
  output logic [15:0] o_arr_wdata,
  input wire logic [15:0] i_arr_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_LD_WAIT, ST_LD_DAT, ST_CHECK, ST_FIX_RD, ST_FIX_WR, ST_PG_RD, ST_PG_WR
  } dbed_state_t;

  // ==========================================================
  // ECC helpers
  function automatic logic [23:0] ecc_acc(input logic [23:0] c, input logic [7:0] w,
                                          input logic [15:0] d);
    logic [23:0] r;
    logic [11:0] pos;
    r = c;
    for (int b = 0; b < 16; b++) begin
      pos = {w, b[3:0]};
      for (int k = 0; k < MAIN_PAIRS; k++) begin
        if (d[b]) begin
          if (pos[k]) r[12+k] = ~r[12+k];
          else r[k] = ~r[k];
        end
      end
    end
    return r;
  endfunction

  // classes a syndrome; fix is set only for a single data-bit error
  function automatic dbed_ecc_t ecc_class(input logic [23:0] syn, input int n,
                                          output logic fix);
    logic comp;
    int ones;
    comp = 1'b1;
    ones = 0;
    for (int k = 0; k < MAIN_PAIRS; k++) begin
      if (k < n) begin
        comp = comp & (syn[k] ^ syn[12+k]);
        ones = ones + int'(syn[k]) + int'(syn[12+k]);
      end
    end
    fix = 1'b0;
    if (ones == 0) return DBED_ECC_NONE;
    if (comp) begin
      fix = 1'b1;
      return DBED_ECC_ONE;
    end
    if (ones == 1) return DBED_ECC_ONE; // flipped bit in the code itself
    return DBED_ECC_TWO;
  endfunction

  // ==========================================================
  // buffers and engine state
  logic [15:0] mem [1024];
  dbed_state_t state;
  logic [IDX_W-1:0] idx;
  logic eng_buf;
  logic [IDX_W-1:0] addr_idx;
  logic bypass;
  logic [BLK_W-1:0] blk;
  logic [PAGE_W-1:0] page;
  logic [SECT_W-1:0] sect;
  logic [23:0] acc_m;
  logic [23:0] acc_s;
  logic [23:0] st_m;
  logic [9:0] st_s;
  logic fix_m;
  logic fix_s;
  logic [15:0] eng_rd;
  logic eng_we;
  logic [15:0] eng_wd;
  logic [23:0] syn_m;
  logic [23:0] syn_s;
  logic abort;
  logic last;

  assign abort = bus.ad_wr && state != ST_IDLE;
  assign last = idx == W_LAST;
  // a read request leaves on the edge that advances idx, so its address runs one ahead
  assign addr_idx = state == ST_IDLE ? '0 : state == ST_LD_DAT ? idx + 1'b1 : idx;
  assign syn_m = acc_m ^ st_m;
  assign syn_s = {7'h00, acc_s[16:12] ^ st_s[9:5], 7'h00, acc_s[4:0] ^ st_s[4:0]};
  assign bus.busy = state != ST_IDLE;

  // host port and engine port are independent, so the idle buffer stays open
  always_ff @(posedge i_core_clk) begin
    if (bus.hb_wr) mem[{bus.hb_sel, bus.hb_addr}] <= bus.hb_wdata;
    if (eng_we) mem[{eng_buf, idx}] <= eng_wd;
  end

  always_ff @(posedge i_core_clk) begin
    bus.hb_rdata <= mem[{bus.hb_sel, bus.hb_addr}];
    eng_rd <= mem[{eng_buf, idx}];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) bus.hb_rvalid <= 1'b0;
    else bus.hb_rvalid <= bus.hb_rd;
  end

  always_comb begin
    eng_we = 1'b0;
    eng_wd = i_arr_rdata;
    if (state == ST_LD_DAT) begin
      eng_we = 1'b1; // stored code words copied as read
    end else if (state == ST_FIX_WR) begin
      eng_we = 1'b1;
      eng_wd = eng_rd ^ (16'h0001 << (fix_m ? syn_m[15:12] : syn_s[15:12]));
    end
  end

  // ==========================================================
  // address registers
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      blk <= '0;
      page <= '0;
      sect <= '0;
    end else if (bus.ad_wr) begin
      blk <= bus.ad_blk;
      page <= bus.ad_page;
      sect <= bus.ad_sect;
    end
  end

  // ==========================================================
  // engine
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      idx <= '0;
      eng_buf <= 1'b0;
      bypass <= 1'b0;
      acc_m <= '0;
      acc_s <= '0;
      st_m <= '0;
      st_s <= '0;
      fix_m <= 1'b0;
      fix_s <= 1'b0;
      o_arr_re <= 1'b0;
      o_arr_we <= 1'b0;
      o_arr_wdata <= '0;
      bus.done <= 1'b0;
      bus.fail <= 1'b0;
      bus.ecc_main <= DBED_ECC_NONE;
      bus.ecc_spare <= DBED_ECC_NONE;
      bus.ecc_valid <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      o_arr_re <= 1'b0;
      o_arr_we <= 1'b0;
      if (abort) begin
        state <= ST_IDLE;
        bus.fail <= 1'b1;
        bus.done <= 1'b1;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (bus.cmd_valid) begin
              idx <= '0;
              acc_m <= '0;
              acc_s <= '0;
              bus.fail <= 1'b0;
              bypass <= bus.cfg1[BYPASS_BIT];
              bus.ecc_valid <= 1'b0;
              eng_buf <= bus.cmd_op == DBED_OP_BOOT ? 1'b0 : bus.cmd_buf;
              if (bus.cmd_op == DBED_OP_PROG) begin
                state <= ST_PG_RD;
              end else begin
                o_arr_re <= 1'b1;
                state <= ST_LD_WAIT;
              end
            end
          end
          ST_LD_WAIT: state <= ST_LD_DAT;
          ST_LD_DAT: begin
            if (idx < IDX_W'(MAIN_WORDS)) acc_m <= ecc_acc(acc_m, idx[7:0], i_arr_rdata);
            if (idx == W_SPECC0 || idx == W_SPECC1) begin
              acc_s <= ecc_acc(acc_s, {7'h00, idx[0]}, i_arr_rdata);
            end
            if (idx == W_CODE0) st_m[15:0] <= i_arr_rdata;
            if (idx == W_CODE1) st_m[23:16] <= i_arr_rdata[7:0];
            if (idx == W_CODE2) st_s <= i_arr_rdata[9:0];
            if (last) begin
              state <= ST_CHECK;
            end else begin
              idx <= idx + 1'b1;
              o_arr_re <= 1'b1;
              state <= ST_LD_WAIT;
            end
          end
          ST_CHECK: begin
            logic fm;
            logic fs;
            dbed_ecc_t cm;
            dbed_ecc_t cs;
            cm = ecc_class(syn_m, MAIN_PAIRS, fm);
            cs = ecc_class(syn_s, SPARE_PAIRS, fs);
            bus.ecc_main <= cm;
            bus.ecc_spare <= cs;
            bus.ecc_valid <= !bypass;
            // besides an abort, only an uncorrectable result fails the operation; a marked block is left to the host's marker read
            bus.fail <= !bypass && (cm == DBED_ECC_TWO || cs == DBED_ECC_TWO);
            fix_m <= fm && !bypass;
            fix_s <= fs && !bypass;
            if (fm && !bypass) begin
              idx <= {1'b0, syn_m[23:16]};
              state <= ST_FIX_RD;
            end else if (fs && !bypass) begin
              idx <= W_SPECC0 + {8'h00, syn_s[16]};
              state <= ST_FIX_RD;
            end else begin
              state <= ST_IDLE;
              bus.done <= 1'b1;
            end
          end
          ST_FIX_RD: state <= ST_FIX_WR;
          ST_FIX_WR: begin
            // done is held back until every correction has landed
            if (fix_m) begin
              fix_m <= 1'b0;
            end else begin
              fix_s <= 1'b0;
            end
            if (fix_m && fix_s) begin
              idx <= W_SPECC0 + {8'h00, syn_s[16]};
              state <= ST_FIX_RD;
            end else begin
              state <= ST_IDLE;
              bus.done <= 1'b1;
            end
          end
          ST_PG_RD: state <= ST_PG_WR;
          ST_PG_WR: begin
            logic [23:0] nm;
            logic [23:0] ns;
            nm = acc_m;
            ns = acc_s;
            if (idx < IDX_W'(MAIN_WORDS)) nm = ecc_acc(acc_m, idx[7:0], eng_rd);
            if (idx == W_SPECC0 || idx == W_SPECC1) ns = ecc_acc(acc_s, {7'h00, idx[0]}, eng_rd);
            acc_m <= nm;
            acc_s <= ns;
            o_arr_wdata <= eng_rd;
            o_arr_we <= 1'b1;
            if (idx == W_CODE0) o_arr_wdata <= nm[15:0];
            if (idx == W_CODE1) o_arr_wdata <= {8'hFF, nm[23:16]};
            if (idx == W_CODE2) o_arr_wdata <= {6'h3F, ns[16:12], ns[4:0]};
            // bypass leaves the code words of the array untouched
            if (bypass && (idx == W_CODE0 || idx == W_CODE1 || idx == W_CODE2)) begin
              o_arr_we <= 1'b0;
            end
            if (last) begin
              state <= ST_IDLE;
              bus.done <= 1'b1;
            end else begin
              idx <= idx + 1'b1;
              state <= ST_PG_RD;
            end
          end
        endcase
      end
    end
  end

  // address of the word the array is working on
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) o_arr_addr <= '0;
    else o_arr_addr <= {blk, page, sect, addr_idx};
  end
endmodule

// file: hdl/dbed_host.sv
/*
  Host end: sequences address, command and wait for each operation,
  guards buffer access and keeps a record of invalid blocks.
  Assumes a user that presents one operation at a time.
*/
`timescale 1ns/1ps
module dbed_host
  import dbed_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  dbed_if.host bus,
  input wire logic i_op_valid,
  input wire dbed_op_t i_op,
  input wire logic i_op_buf,
  input wire logic [BLK_W-1:0] i_op_blk,
  input wire logic [PAGE_W-1:0] i_op_page,
  input wire logic [SECT_W-1:0] i_op_sect,
  input wire logic [15:0] i_cfg1,
  output logic o_op_ready,
  output logic o_op_done,
  output logic o_op_fail,
  input wire logic i_usr_sel,
  input wire logic [IDX_W-1:0] i_usr_addr,
  input wire logic i_usr_wr,
  input wire logic i_usr_rd,
  input wire logic [15:0] i_usr_wdata,
  output logic [15:0] o_usr_rdata,
  output logic o_usr_rvalid,
  output logic o_usr_refused,
  output logic o_bad_valid,
  output logic [BLK_W-1:0] o_bad_blk
);
  typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_WAIT} dbed_hstate_t;
  dbed_hstate_t state;
  dbed_op_t op;
  logic op_buf;
  logic [BLK_W-1:0] blk;
  logic blocked;
  logic rd_mark;

  // ==========================================================
  // buffer access: the buffer in use by the engine is off limits
  assign blocked = state != HS_IDLE && i_usr_sel == (op == DBED_OP_BOOT ? 1'b0 : op_buf);
  assign bus.hb_sel = i_usr_sel;
  assign bus.hb_addr = i_usr_addr;
  assign bus.hb_rd = i_usr_rd && !blocked;
  assign bus.hb_wr = i_usr_wr && !blocked;
  assign bus.hb_wdata = i_usr_wdata;
  assign bus.cfg1 = i_cfg1;
  assign o_op_ready = state == HS_IDLE;
  assign o_usr_rdata = bus.hb_rdata;
  assign o_usr_rvalid = bus.hb_rvalid;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) o_usr_refused <= 1'b0;
    else o_usr_refused <= (i_usr_rd || i_usr_wr) && blocked;
  end

  // ==========================================================
  // operation sequencing; addresses are written only when idle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= HS_IDLE;
      op <= DBED_OP_LOAD;
      op_buf <= 1'b0;
      blk <= '0;
      bus.ad_wr <= 1'b0;
      bus.ad_blk <= '0;
      bus.ad_page <= '0;
      bus.ad_sect <= '0;
      bus.cmd_valid <= 1'b0;
      bus.cmd_op <= DBED_OP_LOAD;
      bus.cmd_buf <= 1'b0;
      o_op_done <= 1'b0;
      o_op_fail <= 1'b0;
    end else begin
      bus.ad_wr <= 1'b0;
      bus.cmd_valid <= 1'b0;
      o_op_done <= 1'b0;
      unique case (state)
        HS_IDLE: begin
          if (i_op_valid) begin
            op <= i_op;
            op_buf <= i_op_buf;
            blk <= i_op_blk;
            bus.ad_wr <= 1'b1;
            bus.ad_blk <= i_op_blk;
            bus.ad_page <= i_op_page;
            bus.ad_sect <= i_op_sect;
            state <= HS_CMD;
          end
        end
        HS_CMD: begin
          bus.cmd_valid <= 1'b1;
          bus.cmd_op <= op;
          bus.cmd_buf <= op_buf;
          state <= HS_WAIT;
        end
        HS_WAIT: begin
          // load failures are reported but not treated as fatal
          if (bus.done) begin
            o_op_done <= 1'b1;
            o_op_fail <= bus.fail;
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // invalid-block record: marker reads and failed programs
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) rd_mark <= 1'b0;
    else rd_mark <= bus.hb_rd && bus.hb_addr == W_MARK;
  end

  // no erase is ever issued, so factory marks survive
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_bad_valid <= 1'b0;
      o_bad_blk <= '0;
    end else begin
      o_bad_valid <= 1'b0;
      if (rd_mark && bus.hb_rdata != MARK_GOOD) begin
        o_bad_valid <= 1'b1;
        o_bad_blk <= blk;
      end else if (state == HS_WAIT && bus.done && bus.fail && op == DBED_OP_PROG) begin
        o_bad_valid <= 1'b1; // user relocates the pages then retires it
        o_bad_blk <= blk;
      end
    end
  end
endmodule

// file: tb/dbed_link_checker.sv
/* checker on the host/device link signals
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/1ps
module dbed_link_checker
  import dbed_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic hb_rd,
  input wire logic hb_rvalid,
  input wire logic ad_wr,
  input wire logic cmd_valid,
  input wire dbed_op_t cmd_op,
  input wire logic [15:0] cfg1,
  input wire logic busy,
  input wire logic done,
  input wire logic fail,
  input wire dbed_ecc_t ecc_main,
  input wire dbed_ecc_t ecc_spare,
  input wire logic ecc_valid
);
  // ==========================================================
  // operation tracking
  logic byp_load;
  logic ecc_load;
  logic aborted;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || (cmd_valid && !busy)) begin
      byp_load <= !i_sys_rst && cmd_op != DBED_OP_PROG && cfg1[BYPASS_BIT];
      ecc_load <= !i_sys_rst && cmd_op != DBED_OP_PROG && !cfg1[BYPASS_BIT];
      aborted <= 1'b0;
    end else if (busy && ad_wr) begin
      aborted <= 1'b1;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_start;
    cmd_valid && !busy;
  endsequence
  sequence s_abort;
    busy && ad_wr;
  endsequence
  a_read_answer: assert property (hb_rd |=> hb_rvalid)
    else $error("buffer read not answered");
  a_rvalid_cause: assert property (hb_rvalid |-> $past(hb_rd))
    else $error("read answer without request");
  a_cmd_takes: assert property (s_start |=> busy)
    else $error("command not taken");
  a_op_bounded: assert property (s_start |-> ##[2:1000] done)
    else $error("operation did not complete");
  a_abort_fails: assert property (s_abort |=> done && fail && !busy)
    else $error("address write did not fail the operation");
  a_bypass_status: assert property (done && byp_load |-> !ecc_valid)
    else $error("bypass load reports ecc status");
  a_ecc_status: assert property (done && ecc_load && !aborted |-> ecc_valid)
    else $error("ecc load left status invalid");
  a_addr_held: assert property (busy |-> !ad_wr)
    else $error("address written during an operation");
  a_two_fails: assert property (done && ecc_valid &&
    (ecc_main == DBED_ECC_TWO || ecc_spare == DBED_ECC_TWO) |-> fail)
    else $error("uncorrectable error not failed");
endmodule

// file: tb/testbench.sv
/* bench: host and device on one link with an array model, and a lone
   device driven directly for abort cases; one 200 MHz clock */
`timescale 1ns/1ps
module testbench
  import dbed_pkg::*;
;
  logic clk, rst, ov, obuf, us, uw, ur, ordy, odone, ofail, urv, uref, bv;
  logic are, awe, bseen, f, r, bf;
  dbed_op_t op;
  logic [BLK_W-1:0] oblk, bb, bblk, b1, b3, b4;
  logic [PAGE_W-1:0] opg;
  logic [SECT_W-1:0] osec;
  logic [IDX_W-1:0] ua;
  logic [15:0] cfg, ud, urd, awd, ard, q;
  logic [ARR_AW-1:0] aadr;
  logic [15:0] arr [int];
  logic [15:0] dat [264];
  logic [15:0] sc [3];
  int seed, i, m, w;
  int bad_count = 0;
  int comparisons = 0;
  dbed_if ifc ();
  dbed_if ifc2 ();
  dbed_host dbed_host_inst (.i_core_clk(clk), .i_sys_rst(rst), .bus(ifc), .i_op_valid(ov),
    .i_op(op), .i_op_buf(obuf), .i_op_blk(oblk), .i_op_page(opg), .i_op_sect(osec),
    .i_cfg1(cfg), .o_op_ready(ordy), .o_op_done(odone), .o_op_fail(ofail), .i_usr_sel(us),
    .i_usr_addr(ua), .i_usr_wr(uw), .i_usr_rd(ur), .i_usr_wdata(ud), .o_usr_rdata(urd),
    .o_usr_rvalid(urv), .o_usr_refused(uref), .o_bad_valid(bv), .o_bad_blk(bb));
  dbed_device dbed_device_inst (.i_core_clk(clk), .i_sys_rst(rst), .bus(ifc), .o_arr_re(are),
    .o_arr_we(awe), .o_arr_addr(aadr), .o_arr_wdata(awd), .i_arr_rdata(ard));
  dbed_device dbed_device_inst_b (.i_core_clk(clk), .i_sys_rst(rst), .bus(ifc2), .o_arr_re(),
    .o_arr_we(), .o_arr_addr(), .o_arr_wdata(), .i_arr_rdata(16'h5A5A));
  dbed_link_checker dbed_link_checker_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .hb_rd(ifc.hb_rd), .hb_rvalid(ifc.hb_rvalid), .ad_wr(ifc.ad_wr), .cmd_valid(ifc.cmd_valid),
    .cmd_op(ifc.cmd_op), .cfg1(ifc.cfg1), .busy(ifc.busy), .done(ifc.done), .fail(ifc.fail),
    .ecc_main(ifc.ecc_main), .ecc_spare(ifc.ecc_spare), .ecc_valid(ifc.ecc_valid));
  // ==========================================================
  // clock, array model, bad-block monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // unread cycles toggle the data so a stale word never looks valid
  always @(posedge clk) begin
    if (awe === 1'b1) arr[int'(aadr)] = awd;
    if (are === 1'b1) ard <= arr.exists(int'(aadr)) ? arr[int'(aadr)] : 16'hFFFF;
    else ard <= ~ard;
    if (bv === 1'b1) begin
      bseen <= 1'b1;
      bblk <= bb;
    end
  end
  // ==========================================================
  // helpers
  function automatic int key(input logic [BLK_W-1:0] bk, input int x);
    return int'({bk, opg, osec, x[IDX_W-1:0]});
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask
  task automatic run_op(input dbed_op_t o, input logic b, input logic [BLK_W-1:0] bk,
      input logic [15:0] c, output logic fo);
    int n;
    while (ordy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    ov = 1'b1;
    op = o;
    obuf = b;
    oblk = bk;
    cfg = c;
    @(posedge clk);
    #1;
    ov = 1'b0;
    for (n = 0; n < 3000 && odone !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chkb(odone, 1'b1);
    fo = ofail;
  endtask
  task automatic bacc(input logic b, input logic [IDX_W-1:0] a, input logic wr,
      input logic [15:0] d, output logic [15:0] qo, output logic ro);
    int n;
    us = b;
    ua = a;
    uw = wr;
    ur = !wr;
    ud = d;
    @(posedge clk);
    #1;
    uw = 1'b0;
    ur = 1'b0;
    qo = urd;
    ro = uref;
    for (n = 0; n < 3 && !wr && urv !== 1'b1 && ro !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      qo = urd;
      ro = uref;
    end
    // one idle edge so the next call never re-raises a strobe in the same step
    @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = 17;
    {ov, obuf, us, uw, ur, bseen, ard, ud, cfg, ua, oblk} = '0;
    op = DBED_OP_LOAD;
    {ifc2.hb_sel, ifc2.hb_wr, ifc2.hb_rd, ifc2.ad_wr, ifc2.cmd_valid, ifc2.cmd_buf} = '0;
    {ifc2.hb_addr, ifc2.hb_wdata, ifc2.ad_blk, ifc2.ad_page, ifc2.ad_sect, ifc2.cfg1} = '0;
    ifc2.cmd_op = DBED_OP_LOAD;
    opg = PAGE_W'($random(seed));
    osec = SECT_W'($random(seed));
    b1 = BLK_W'($random(seed));
    b3 = b1 + 10'h002;
    b4 = b1 + 10'h003;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 264; i++) begin
      dat[i] = (i == 257) ? MARK_GOOD : 16'($random(seed));
      bacc(1'b0, i[IDX_W-1:0], 1'b1, dat[i], q, r);
    end
    run_op(DBED_OP_PROG, 1'b0, b1, 16'h0000, f);
    run_op(DBED_OP_PROG, 1'b0, b1 + 10'h001, 16'h0200, f);
    for (i = 0; i < 3; i++) begin
      chkb(arr.exists(key(b1, 260 + i)) != 0, 1'b1);
      chkb(arr.exists(key(b1 + 10'h001, 260 + i)) != 0, 1'b0);
      sc[i] = arr[key(b1, 260 + i)];
    end
    // modes: clean, one main flip, boot with spare flip, two flips, bypass
    for (m = 0; m < 5; m++) begin
      w = (m == 2) ? 258 : {$random(seed)} % 256;
      bf = (m != 2);
      arr[key(b1, w)] = dat[w] ^ (m == 0 ? 16'h0000 : m == 3 ? 16'h0011 : 16'h0100);
      bacc(bf, w[IDX_W-1:0], 1'b1, ~dat[w], q, r);
      run_op(m == 2 ? DBED_OP_BOOT : DBED_OP_LOAD, 1'b1, b1, m == 4 ? 16'h0200 : 16'h0000, f);
      chkb(f, m == 3);
      if (m < 4) begin
        chk(16'(ifc.ecc_main), m == 1 ? 16'h0001 : m == 3 ? 16'h0002 : 16'h0000);
        chk(16'(ifc.ecc_spare), m == 2 ? 16'h0001 : 16'h0000);
      end
      for (i = 0; i < 263; i++) begin
        if (m == 3 && i == w) continue;
        bacc(bf, i[IDX_W-1:0], 1'b0, 16'h0000, q, r);
        chk(q, i > 259 ? sc[i - 260] : (m == 4 && i == w) ? dat[i] ^ 16'h0100 : dat[i]);
      end
      arr[key(b1, w)] = dat[w];
    end
    fork
      run_op(DBED_OP_LOAD, 1'b1, b1, 16'h0000, f);
      begin
        repeat (20) @(posedge clk);
        #1;
        for (i = 0; i < 16; i++) begin
          bacc(1'b0, i[IDX_W-1:0], 1'b0, 16'h0000, q, r);
          chk(q, dat[i]);
        end
        bacc(1'b1, 9'h000, 1'b0, 16'h0000, q, r);
        chkb(r, 1'b1);
      end
    join
    fork
      run_op(DBED_OP_PROG, 1'b1, b3, 16'h0000, f);
      begin
        repeat (20) @(posedge clk);
        #1;
        for (i = 0; i < 16; i++) bacc(1'b0, i[IDX_W-1:0], 1'b1, ~dat[i], q, r);
        bacc(1'b1, 9'h000, 1'b1, 16'h0000, q, r);
        chkb(r, 1'b1);
      end
    join
    for (i = 0; i < 16; i++) begin
      bacc(1'b0, i[IDX_W-1:0], 1'b0, 16'h0000, q, r);
      chk(q, ~dat[i]);
      chk(arr[key(b3, i)], dat[i]);
    end
    arr[key(b4, 257)] = 16'h00F0;
    bseen = 1'b0;
    run_op(DBED_OP_LOAD, 1'b1, b4, 16'h0000, f);
    bacc(1'b1, W_MARK, 1'b0, 16'h0000, q, r);
    repeat (3) @(posedge clk);
    #1;
    chk(q, 16'h00F0);
    chkb(bseen, 1'b1);
    chk(16'(bblk), 16'(b4));
    for (m = 0; m < 2; m++) begin
      ifc2.cmd_op = m ? DBED_OP_PROG : DBED_OP_LOAD;
      ifc2.cmd_valid = 1'b1;
      @(posedge clk);
      #1 ifc2.cmd_valid = 1'b0;
      repeat (20) @(posedge clk);
      #1 ifc2.ad_wr = 1'b1;
      chkb(ifc2.busy, 1'b1);
      @(posedge clk);
      #1 ifc2.ad_wr = 1'b0;
      chkb(ifc2.done & ifc2.fail & ~ifc2.busy, 1'b1);
      repeat (3) @(posedge clk);
      #1;
    end
    stop_test();
  end
  // hang guard: nearly five times the expected run length
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
